// *** rtl/indirect_data_addressing.sv ***
// pointer registers, accumulator, bank and flags with indirect memory ports
`timescale 1ns/1ps
module indirect_data_addressing (
   input wire logic clk, // core clock, 10 MHz
   input wire logic rstn, // async reset, active low
   input wire logic [6:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data, byte in low lane
   input wire logic [3:0] avs_byteenable, // lane enables
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // low on the completing cycle
   output logic [7:0] working_accumulator, // accumulator to the core
   output logic [3:0] bank_selector, // bank select to the core
   output logic [4:0] arith_flags // flags to the core
);

   // ==========================================================
   // state
   ida_pkg::bus_state_t state_q;
   ida_pkg::bus_state_t state_d;
   logic [7:0] ptr0_lo_q;
   logic [7:0] accum_q;
   logic [3:0] bank_q;
   logic [4:0] flags_q;
   logic [11:0] ptr_q [ida_pkg::NUM_PTR];
   logic [31:0] readdata_q;

   logic req;
   logic [6:0] addr_w;
   logic wr_lane;
   logic commit;
   logic [ida_pkg::NUM_PTR-1:0] port_hit;
   logic [ida_pkg::NUM_PTR-1:0] hi_hit;
   logic [ida_pkg::NUM_PTR-1:0] lo_hit;
   ida_pkg::port_mode_t mode [ida_pkg::NUM_PTR];
   logic [11:0] ea [ida_pkg::NUM_PTR];
   logic [11:0] next [ida_pkg::NUM_PTR];
   logic any_port;
   logic [11:0] mem_addr;
   logic [7:0] mem_rdata;
   logic [7:0] rd_mux;

   assign req = avs_read | avs_write;
   assign addr_w = {avs_address[6:2], 2'b00};
   assign wr_lane = avs_write & avs_byteenable[0];
   assign commit = (state_q == ida_pkg::ST_ACK);

   // ==========================================================
   // per pointer decode and address arithmetic
   generate
      for (genvar g = 0; g < ida_pkg::NUM_PTR; g++) begin : g_ptr
         localparam logic [6:0] BASE = (g == 0) ? ida_pkg::OFF_P1_PORTS : ida_pkg::OFF_P2_PORTS;
         localparam logic [6:0] HI = (g == 0) ? ida_pkg::OFF_P1_HI : ida_pkg::OFF_P2_HI;
         localparam logic [6:0] LO = (g == 0) ? ida_pkg::OFF_P1_LO : ida_pkg::OFF_P2_LO;
         logic [6:0] rel;

         assign rel = addr_w - BASE;
         assign port_hit[g] = (addr_w >= BASE) && (addr_w < BASE + ida_pkg::PORT_SPAN);
         assign hi_hit[g] = (addr_w == HI);
         assign lo_hit[g] = (addr_w == LO);
         assign mode[g] = ida_pkg::port_mode_t'(rel[4:2]);

         pointer_step u_step (
            .ptr(ptr_q[g]),
            .mode(mode[g]),
            .accum(accum_q),
            .ea(ea[g]),
            .next(next[g])
         );

         // steps land on the completing edge, after the address was used
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               ptr_q[g] <= ida_pkg::RST_PTR;
            end else if (commit && port_hit[g]) begin
               ptr_q[g] <= next[g];
            end else if (commit && wr_lane && hi_hit[g]) begin
               ptr_q[g][11:8] <= avs_writedata[3:0];
            end else if (commit && wr_lane && lo_hit[g]) begin
               ptr_q[g][7:0] <= avs_writedata[7:0];
            end
         end

         a_plain_keeps_ptr: assert property (@(posedge clk) disable iff (!rstn)
            commit && port_hit[g] && mode[g] == ida_pkg::PM_PLAIN |=> $stable(ptr_q[g]))
            else $error("plain port changed its pointer");

         a_post_step_ptr: assert property (@(posedge clk) disable iff (!rstn)
            commit && port_hit[g] && mode[g] == ida_pkg::PM_POST_INC
            |=> ptr_q[g] == $past(ptr_q[g]) + 12'h001)
            else $error("post-increment did not step pointer");

         a_wrap_on_dec: assert property (@(posedge clk) disable iff (!rstn)
            commit && port_hit[g] && mode[g] == ida_pkg::PM_POST_DEC && ptr_q[g] == 12'h000
            |=> ptr_q[g] == 12'hFFF)
            else $error("pointer decrement did not wrap");

         a_pre_inc_addr: assert property (@(posedge clk) disable iff (!rstn)
            state_q == ida_pkg::ST_IDLE && avs_read && port_hit[g]
            && mode[g] == ida_pkg::PM_PRE_INC |-> mem_addr == ptr_q[g] + 12'h001)
            else $error("pre-increment port used stale address");

         a_offset_addr: assert property (@(posedge clk) disable iff (!rstn)
            state_q == ida_pkg::ST_IDLE && avs_read && port_hit[g]
            && mode[g] == ida_pkg::PM_PLUS_ACC |-> mem_addr == ptr_q[g] + {4'h0, accum_q})
            else $error("offset port address wrong");

         a_post_dec_step: assert property (@(posedge clk) disable iff (!rstn)
            commit && port_hit[g] && mode[g] == ida_pkg::PM_POST_DEC
            |=> ptr_q[g] == $past(ptr_q[g]) - 12'h001)
            else $error("post-decrement did not step pointer");

         a_pre_inc_step: assert property (@(posedge clk) disable iff (!rstn)
            commit && port_hit[g] && mode[g] == ida_pkg::PM_PRE_INC
            |=> ptr_q[g] == $past(ptr_q[g]) + 12'h001)
            else $error("pre-increment did not step pointer");

         a_offset_keeps_ptr: assert property (@(posedge clk) disable iff (!rstn)
            commit && port_hit[g] && mode[g] == ida_pkg::PM_PLUS_ACC
            |=> $stable(ptr_q[g]))
            else $error("offset port changed its pointer");

         a_wrap_on_inc: assert property (@(posedge clk) disable iff (!rstn)
            commit && port_hit[g] && mode[g] == ida_pkg::PM_POST_INC && ptr_q[g] == 12'hFFF
            |=> ptr_q[g] == 12'h000)
            else $error("pointer increment did not wrap");

         a_plain_addr: assert property (@(posedge clk) disable iff (!rstn)
            state_q == ida_pkg::ST_IDLE && req && port_hit[g]
            && mode[g] == ida_pkg::PM_PLAIN |-> mem_addr == ptr_q[g])
            else $error("plain port address wrong");

         a_post_addr: assert property (@(posedge clk) disable iff (!rstn)
            state_q == ida_pkg::ST_IDLE && req && port_hit[g]
            && (mode[g] == ida_pkg::PM_POST_INC || mode[g] == ida_pkg::PM_POST_DEC)
            |-> mem_addr == ptr_q[g])
            else $error("post port did not use current pointer");

         a_pre_inc_write: assert property (@(posedge clk) disable iff (!rstn)
            commit && avs_write && port_hit[g] && mode[g] == ida_pkg::PM_PRE_INC
            |-> mem_addr == ptr_q[g] + 12'h001)
            else $error("pre-increment write used stale address");

         a_hi_write: assert property (@(posedge clk) disable iff (!rstn)
            commit && wr_lane && hi_hit[g]
            |=> ptr_q[g][11:8] == $past(avs_writedata[3:0]))
            else $error("pointer high bits not written");

         a_lo_write: assert property (@(posedge clk) disable iff (!rstn)
            commit && wr_lane && lo_hit[g]
            |=> ptr_q[g][7:0] == $past(avs_writedata[7:0]))
            else $error("pointer low byte not written");

         a_ptr_hold_idle: assert property (@(posedge clk) disable iff (!rstn)
            !commit |=> $stable(ptr_q[g]))
            else $error("pointer moved outside a completing cycle");
      end
   endgenerate

   assign any_port = |port_hit;
   assign mem_addr = port_hit[1] ? ea[1] : ea[0];

   // ==========================================================
   // data memory; the ports only redirect here, no storage of their own
   data_store u_mem (
      .clk(clk),
      .rstn(rstn),
      .wr_en(commit && avs_write && any_port),
      .wr_addr(mem_addr),
      .wr_data(avs_writedata[7:0]),
      .rd_en(state_q == ida_pkg::ST_IDLE && avs_read && any_port),
      .rd_addr(mem_addr),
      .rd_data(mem_rdata)
   );

   // ==========================================================
   // bus sequencer: idle takes request, load fills readdata, ack completes
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ida_pkg::ST_IDLE: begin
            if (req) begin
               state_d = ida_pkg::ST_LOAD;
            end
         end
         ida_pkg::ST_LOAD: begin
            state_d = ida_pkg::ST_ACK;
         end
         ida_pkg::ST_ACK: begin
            state_d = ida_pkg::ST_IDLE;
         end
         default: begin
            state_d = ida_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ida_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign avs_waitrequest = !commit;

   // ==========================================================
   // read path; unimplemented bits come back as zero
   always_comb begin
      rd_mux = 8'h00;
      if (any_port) begin
         rd_mux = mem_rdata;
      end else if (hi_hit[0]) begin
         rd_mux = {4'h0, ptr_q[0][11:8]};
      end else if (hi_hit[1]) begin
         rd_mux = {4'h0, ptr_q[1][11:8]};
      end else if (lo_hit[0]) begin
         rd_mux = ptr_q[0][7:0];
      end else if (lo_hit[1]) begin
         rd_mux = ptr_q[1][7:0];
      end else if (addr_w == ida_pkg::OFF_PTR0_LO) begin
         rd_mux = ptr0_lo_q;
      end else if (addr_w == ida_pkg::OFF_ACCUM) begin
         rd_mux = accum_q;
      end else if (addr_w == ida_pkg::OFF_BANK) begin
         rd_mux = {4'h0, bank_q};
      end else if (addr_w == ida_pkg::OFF_FLAGS) begin
         rd_mux = {3'h0, flags_q};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readdata_q <= 32'h0000_0000;
      end else if (state_q == ida_pkg::ST_LOAD) begin
         readdata_q <= {24'h00_0000, rd_mux};
      end
   end

   assign avs_readdata = readdata_q;

   // ==========================================================
   // plain registers, written on the completing edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr0_lo_q <= ida_pkg::RST_PTR0_LO;
      end else if (commit && wr_lane && addr_w == ida_pkg::OFF_PTR0_LO) begin
         ptr0_lo_q <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         accum_q <= ida_pkg::RST_ACCUM;
      end else if (commit && wr_lane && addr_w == ida_pkg::OFF_ACCUM) begin
         accum_q <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bank_q <= ida_pkg::RST_BANK;
      end else if (commit && wr_lane && addr_w == ida_pkg::OFF_BANK) begin
         bank_q <= avs_writedata[3:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= ida_pkg::RST_FLAGS;
      end else if (commit && wr_lane && addr_w == ida_pkg::OFF_FLAGS) begin
         flags_q <= avs_writedata[4:0];
      end
   end

   assign working_accumulator = accum_q;
   assign bank_selector = bank_q;
   assign arith_flags = flags_q;

   // ==========================================================
   // checks across the bus sequence
   a_port_read_memory: assert property (@(posedge clk) disable iff (!rstn)
      commit && avs_read && any_port |-> avs_readdata[7:0] == $past(mem_rdata))
      else $error("port read did not return memory byte");

   a_ptr_high_zero: assert property (@(posedge clk) disable iff (!rstn)
      commit && avs_read && (|hi_hit) |-> avs_readdata[31:4] == 28'h000_0000)
      else $error("pointer high byte upper bits not zero");

   a_upper_bits_zero: assert property (@(posedge clk) disable iff (!rstn)
      commit && avs_read |-> avs_readdata[31:8] == 24'h00_0000)
      else $error("unimplemented bits read nonzero");

   a_ack_after_two: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ida_pkg::ST_IDLE && req |-> ##2 !avs_waitrequest)
      else $error("answer not on third cycle");

   // ==========================================================
   // register and handshake checks
   a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_readdata_hold: assert property (@(posedge clk) disable iff (!rstn)
      state_q != ida_pkg::ST_LOAD |=> $stable(avs_readdata))
      else $error("read data changed outside the load cycle");

   a_state_onehot: assert property (@(posedge clk) disable iff (!rstn)
      $onehot(state_q))
      else $error("sequencer state not one-hot");

   a_bank_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
      commit && avs_read && addr_w == ida_pkg::OFF_BANK
      |-> avs_readdata[31:4] == 28'h000_0000)
      else $error("bank upper bits not zero");

   a_flags_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
      commit && avs_read && addr_w == ida_pkg::OFF_FLAGS
      |-> avs_readdata[31:5] == 27'h000_0000)
      else $error("flags upper bits not zero");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
      commit && avs_read && addr_w > ida_pkg::OFF_FLAGS |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_accum_write: assert property (@(posedge clk) disable iff (!rstn)
      commit && wr_lane && addr_w == ida_pkg::OFF_ACCUM
      |=> working_accumulator == $past(avs_writedata[7:0]))
      else $error("accumulator not written");

   a_bank_write: assert property (@(posedge clk) disable iff (!rstn)
      commit && wr_lane && addr_w == ida_pkg::OFF_BANK
      |=> bank_selector == $past(avs_writedata[3:0]))
      else $error("bank select not written");

   a_flags_write: assert property (@(posedge clk) disable iff (!rstn)
      commit && wr_lane && addr_w == ida_pkg::OFF_FLAGS
      |=> arith_flags == $past(avs_writedata[4:0]))
      else $error("flags not written");

   a_lane_off_ignored: assert property (@(posedge clk) disable iff (!rstn)
      commit && avs_write && !avs_byteenable[0] && !any_port
      |=> $stable(accum_q) && $stable(bank_q) && $stable(flags_q) && $stable(ptr0_lo_q))
      else $error("write with lane zero off changed a register");

endmodule : indirect_data_addressing

// *** rtl/ida_pkg.sv ***
// constants, offsets and types for the indirect data addressing block
// How it works
// - plain port accesses memory, pointer untouched
// - post ports use pointer, then step it
// - pre-increment port steps pointer, then accesses
// - offset port addresses pointer plus accumulator
// - access ports hold no storage themselves
// - pointer high byte keeps only four bits
// - unimplemented bits always read as zero
package ida_pkg;

   // ==========================================================
   // widths
   localparam int PTR_W = 12;
   localparam int PTR_HI_W = 4;
   localparam int BANK_W = 4;
   localparam int FLAG_W = 5;
   localparam int ADDR_W = 7;
   localparam int NUM_PTR = 2;
   localparam int NUM_PORTS = 5;

   // ==========================================================
   // register byte offsets on the bus
   localparam logic [6:0] OFF_PTR0_LO = 7'h00;
   localparam logic [6:0] OFF_ACCUM = 7'h04;
   localparam logic [6:0] OFF_P1_PORTS = 7'h08;
   localparam logic [6:0] OFF_P1_HI = 7'h1C;
   localparam logic [6:0] OFF_P1_LO = 7'h20;
   localparam logic [6:0] OFF_BANK = 7'h24;
   localparam logic [6:0] OFF_P2_PORTS = 7'h28;
   localparam logic [6:0] OFF_P2_HI = 7'h3C;
   localparam logic [6:0] OFF_P2_LO = 7'h40;
   localparam logic [6:0] OFF_FLAGS = 7'h44;
   localparam logic [6:0] PORT_SPAN = 7'h14;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_PTR0_LO = 8'h00;
   localparam logic [7:0] RST_ACCUM = 8'h00;
   localparam logic [11:0] RST_PTR = 12'h000;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic [4:0] RST_FLAGS = 5'h00;

   // ==========================================================
   // access port modes, in address order within a pointer's group
   typedef enum logic [2:0] {
      PM_PLAIN = 3'h0,
      PM_POST_INC = 3'h1,
      PM_POST_DEC = 3'h2,
      PM_PRE_INC = 3'h3,
      PM_PLUS_ACC = 3'h4
   } port_mode_t;

   // bus transaction sequencer
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_LOAD = 3'h2,
      ST_ACK = 3'h4
   } bus_state_t;

endpackage : ida_pkg

// *** rtl/pointer_step.sv ***
// effective address and next value of one pointer for a given access port
`timescale 1ns/1ps
module pointer_step (
   input wire logic [11:0] ptr, // current pointer value
   input wire ida_pkg::port_mode_t mode, // port being accessed
   input wire logic [7:0] accum, // working accumulator
   output logic [11:0] ea, // data memory address
   output logic [11:0] next // pointer value after the access
);

   logic [11:0] plus_one;
   logic [11:0] minus_one;
   logic [11:0] plus_acc;

   // 12-bit sums: carry from the low byte into the high bits, wrap at the top
   assign plus_one = ptr + 12'h001;
   assign minus_one = ptr - 12'h001;
   assign plus_acc = ptr + {4'h0, accum};

   always_comb begin
      ea = ptr;
      next = ptr;
      unique case (mode)
         ida_pkg::PM_PLAIN: begin
            ea = ptr;
            next = ptr;
         end
         ida_pkg::PM_POST_INC: begin
            ea = ptr;
            next = plus_one;
         end
         ida_pkg::PM_POST_DEC: begin
            ea = ptr;
            next = minus_one;
         end
         ida_pkg::PM_PRE_INC: begin
            ea = plus_one;
            next = plus_one;
         end
         ida_pkg::PM_PLUS_ACC: begin
            ea = plus_acc;
            next = ptr;
         end
         default: begin
            ea = ptr;
            next = ptr;
         end
      endcase
   end

endmodule : pointer_step

// *** rtl/data_store.sv ***
// byte-wide data memory behind the indirect access ports
`timescale 1ns/1ps
module data_store (
   input wire logic clk, // core clock
   input wire logic rstn, // async reset, active low
   input wire logic wr_en, // write strobe
   input wire logic [11:0] wr_addr, // write address
   input wire logic [7:0] wr_data, // write byte
   input wire logic rd_en, // read strobe
   input wire logic [11:0] rd_addr, // read address
   output logic [7:0] rd_data // registered read byte
);

   logic [7:0] mem [0:4095];
   logic [7:0] rd_data_q;

   // array left unreset so it maps onto block memory
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_q <= 8'h00;
      end else if (rd_en) begin
         rd_data_q <= mem[rd_addr];
      end
   end

   assign rd_data = rd_data_q;

endmodule : data_store

// *** bench/core_master.sv ***
// core-side bus master model driving the register bus of the block
`timescale 1ns/1ps
module core_master (
   input wire logic clk, // core clock
   output logic [6:0] avs_address, // byte address
   output logic avs_read, // read request
   output logic avs_write, // write request
   output logic [31:0] avs_writedata, // write data
   output logic [3:0] avs_byteenable, // lane enables
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest // low on the completing cycle
);
   // ==========================================================
   // idle bus
   initial begin
      avs_address = 7'h7F;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end

   // ==========================================================
   // one transfer, entered just after a rising edge
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = 32'h0;
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      // junk in upper lanes, only the low lane may matter
      avs_writedata <= {~d, ~d, ~d, d};
      avs_byteenable <= be;
      for (n = 0; n < 20 && ok == 1'b0; n++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) begin
            ok = 1'b1;
            q = avs_readdata;
         end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // released lines show the inverse, never the stale value
      avs_address <= ~a;
      avs_writedata <= {d, d, d, ~d};
      avs_byteenable <= ~be;
      @(posedge clk);
   endtask : xfer
endmodule : core_master

// *** bench/indirect_data_addressing_test.sv ***
// self-checking bench for the indirect data addressing block
`timescale 1ns/1ps
module indirect_data_addressing_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [6:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] working_accumulator;
   logic [3:0] bank_selector;
   logic [4:0] arith_flags;
   int fail_count = 0;
   int tests_run = 0;
   logic [31:0] seed = 32'h32E30BA7;
   logic [11:0] ptr [2] = '{12'h000, 12'h000};
   logic [7:0] acc_m = 8'h00;
   logic [7:0] ptr0_m = 8'h00;
   logic [3:0] bank_m = 4'h0;
   logic [4:0] flags_m = 5'h00;
   logic [7:0] mem [logic [11:0]];
   logic [6:0] regs [10] = '{ida_pkg::OFF_PTR0_LO, ida_pkg::OFF_ACCUM, ida_pkg::OFF_P1_HI,
      ida_pkg::OFF_P1_LO, ida_pkg::OFF_BANK, ida_pkg::OFF_P2_HI, ida_pkg::OFF_P2_LO,
      ida_pkg::OFF_FLAGS, 7'h48, 7'h7C};

   always #50 clk = ~clk;

   core_master u_core (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   indirect_data_addressing u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .working_accumulator(working_accumulator),
      .bank_selector(bank_selector), .arith_flags(arith_flags));

   // ==========================================================
   // reference model
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [6:0] hi_off(int p);
      return p ? ida_pkg::OFF_P2_HI : ida_pkg::OFF_P1_HI;
   endfunction : hi_off

   function automatic logic [6:0] lo_off(int p);
      return p ? ida_pkg::OFF_P2_LO : ida_pkg::OFF_P1_LO;
   endfunction : lo_off

   function automatic logic [11:0] ea(logic [2:0] m, logic [11:0] p, logic [7:0] a);
      case (m)
         3'h3: return p + 12'h001;
         3'h4: return p + {4'h0, a};
         default: return p;
      endcase
   endfunction : ea

   function automatic logic [11:0] nxt(logic [2:0] m, logic [11:0] p);
      case (m)
         3'h1, 3'h3: return p + 12'h001;
         3'h2: return p - 12'h001;
         default: return p;
      endcase
   endfunction : nxt

   function automatic logic [31:0] exp_reg(logic [6:0] a);
      case (a)
         ida_pkg::OFF_PTR0_LO: return {24'h0, ptr0_m};
         ida_pkg::OFF_ACCUM: return {24'h0, acc_m};
         ida_pkg::OFF_P1_HI: return {28'h0, ptr[0][11:8]};
         ida_pkg::OFF_P1_LO: return {24'h0, ptr[0][7:0]};
         ida_pkg::OFF_BANK: return {28'h0, bank_m};
         ida_pkg::OFF_P2_HI: return {28'h0, ptr[1][11:8]};
         ida_pkg::OFF_P2_LO: return {24'h0, ptr[1][7:0]};
         ida_pkg::OFF_FLAGS: return {27'h0, flags_m};
         default: return 32'h0;
      endcase
   endfunction : exp_reg

   // ==========================================================
   // checking and bus tasks
   task automatic end_sim();
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      logic ok;
      u_core.xfer(wr, a, d, be, q, ok);
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED bus answer expected 1 seen 0");
         end_sim();
      end
   endtask : bus

   task automatic reg_wr(input logic [6:0] a, input logic [7:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
      if (be[0]) begin
         case (a)
            ida_pkg::OFF_PTR0_LO: ptr0_m = d;
            ida_pkg::OFF_ACCUM: acc_m = d;
            ida_pkg::OFF_P1_HI: ptr[0][11:8] = d[3:0];
            ida_pkg::OFF_P1_LO: ptr[0][7:0] = d;
            ida_pkg::OFF_BANK: bank_m = d[3:0];
            ida_pkg::OFF_P2_HI: ptr[1][11:8] = d[3:0];
            ida_pkg::OFF_P2_LO: ptr[1][7:0] = d;
            ida_pkg::OFF_FLAGS: flags_m = d[4:0];
            default: ;
         endcase
      end
   endtask : reg_wr

   task automatic rd_chk(input logic [6:0] a);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 4'hF, q);
      check("register", exp_reg(a), q);
   endtask : rd_chk

   task automatic port(input int p, input logic [2:0] m, input logic wr, input logic [7:0] d,
                       input logic [3:0] be);
      logic [11:0] a;
      logic [31:0] q;
      a = ea(m, ptr[p], acc_m);
      bus(wr, (p ? ida_pkg::OFF_P2_PORTS : ida_pkg::OFF_P1_PORTS) + {2'h0, m, 2'h0}, d, be, q);
      if (wr) begin
         mem[a] = d;
      end else if (mem.exists(a)) begin
         check("port read", {24'h0, mem[a]}, q);
      end
      ptr[p] = nxt(m, ptr[p]);
   endtask : port

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] r;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (regs[i]) rd_chk(regs[i]);
      // fill all of data memory so no port read meets an unwritten byte
      repeat (4096) port(0, 3'h1, 1'b1, 8'(xs()), 4'hF);
      foreach (regs[i]) begin
         reg_wr(regs[i], 8'hFF, 4'hF);
         rd_chk(regs[i]);
      end
      for (int p = 0; p < 2; p++) begin
         reg_wr(hi_off(p), 8'h0F, 4'hF);
         reg_wr(lo_off(p), 8'hFF, 4'hF);
         port(p, 3'h1, 1'b1, 8'hA5 ^ 8'(p), 4'hF);
         port(p, 3'h0, 1'b1, 8'h3C, 4'hE);
         port(p, 3'h2, 1'b0, 8'h00, 4'hF);
         port(p, 3'h0, 1'b0, 8'h00, 4'hF);
         port(p, 3'h3, 1'b0, 8'h00, 4'hF);
         reg_wr(ida_pkg::OFF_ACCUM, 8'hFF, 4'hF);
         reg_wr(hi_off(p), 8'h0F, 4'hF);
         reg_wr(lo_off(p), 8'h01, 4'hF);
         port(p, 3'h4, 1'b0, 8'h00, 4'hF);
         rd_chk(hi_off(p));
         rd_chk(lo_off(p));
      end
      repeat (400) begin
         r = xs();
         case (r[3:1])
            3'h0: reg_wr(regs[r[31:24] % 10], r[15:8], (r[18:16] == 3'h0) ? 4'hE : 4'hF);
            3'h1: rd_chk(regs[r[31:24] % 10]);
            default: port(r[0], 3'(r[31:20] % 5), r[4], r[15:8],
                          (r[18:16] == 3'h0) ? 4'hE : 4'hF);
         endcase
         check("core outputs", {15'h0, acc_m, bank_m, flags_m},
               {15'h0, working_accumulator, bank_selector, arith_flags});
      end
      end_sim();
   end
endmodule : indirect_data_addressing_test
